// >>> hdl/als_persistence_and_aux_pin.sv
// Light interrupt persistence filter and auxiliary pin control with their registers
`timescale 1ns/100ps
`default_nettype none
module als_persistence_and_aux_pin #(
  parameter int unsigned CHANNELS = 5,
  parameter int unsigned DATA_W   = 16,
  parameter int unsigned SEL_W    = 3
) (
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  input  wire als_aux_pkg::reg_req_t             reg_req,
  output logic [als_aux_pkg::REG_DATA_W-1:0]     reg_rdata,
  output logic                                   reg_rvalid,
  input  wire logic                              light_sample_valid,
  input  wire logic [CHANNELS-1:0][DATA_W-1:0]   light_result,
  input  wire logic [SEL_W-1:0]                  light_threshold_source_select,
  input  wire logic [DATA_W-1:0]                 light_low_threshold,
  input  wire logic [DATA_W-1:0]                 light_high_threshold,
  input  wire logic                              light_irq_direct_en,
  input  wire logic                              aux_pin_irq_routing,
  input  wire logic                              aux_pin_in,
  output logic                                   aux_pin_out,
  output logic                                   aux_pin_oe_n,
  output logic                                   light_irq,
  output logic                                   light_irq_level,
  output logic [als_aux_pkg::PROX_PERSIST_W-1:0] prox_persist_count
);

  typedef struct packed {
    logic [7:0]              persist_filter;
    logic [7:0]              aux_ctrl;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    sample_valid;
    logic                    out_of_range;
    als_aux_pkg::pin_drive_t pin;
  } top_state_t;

  top_state_t        state;
  top_state_t        next_state;
  logic              pin_sync;
  logic              filter_irq;
  logic              filter_met;
  logic [DATA_W-1:0] selected;
  logic [3:0]        light_persist_count;
  logic              aux_invert;
  logic              aux_in_en;
  logic              aux_out;
  logic              routed_value;
  logic              pin_value;
  logic [7:0]        aux_readback;

  sync_two_stage u_pin_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in (aux_pin_in),
    .sync_out (pin_sync)
  );

  light_persist_filter #(
    .COUNT_W (als_aux_pkg::COUNT_W)
  ) u_filter (
    .clk_sys             (clk_sys),
    .reset               (reset),
    .sample_valid        (state.sample_valid),
    .out_of_range        (state.out_of_range),
    .light_persist_count (light_persist_count),
    .irq_pulse           (filter_irq),
    .persist_met         (filter_met)
  );

  assign light_persist_count = state.persist_filter[als_aux_pkg::LIGHT_PERSIST_LSB +: als_aux_pkg::LIGHT_PERSIST_W];
  assign aux_invert = state.aux_ctrl[als_aux_pkg::AUX_INVERT_BIT];
  assign aux_in_en  = state.aux_ctrl[als_aux_pkg::AUX_IN_EN_BIT];
  assign aux_out    = state.aux_ctrl[als_aux_pkg::AUX_OUT_BIT];

  // Out-of-range select falls back to channel zero rather than reading past the array
  always_comb begin
    if (light_threshold_source_select < SEL_W'(CHANNELS)) begin
      selected = light_result[light_threshold_source_select];
    end else begin
      selected = light_result[0];
    end
  end

  // Routed interrupt is active low on the pin unless the invert bit is set, unlike the active-high light_irq output
  always_comb begin
    if (aux_pin_irq_routing) begin
      if (light_irq_direct_en) begin
        routed_value = ~filter_met;
      end else begin
        routed_value = ~filter_met;
      end
    end else begin
      routed_value = aux_out;
    end
  end

  assign pin_value = routed_value ^ aux_invert;

  // The input bit is a live view of the pin only while input is enabled, so writes to it are discarded
  always_comb begin
    aux_readback = state.aux_ctrl & als_aux_pkg::AUX_PIN_WMASK;
    aux_readback[als_aux_pkg::AUX_IN_BIT] = aux_in_en & pin_sync;
  end

  always_comb begin
    next_state              = state;
    next_state.rvalid       = 1'b0;
    // Compare one cycle ahead of the filter to keep the wide compare off the counter path
    next_state.sample_valid = light_sample_valid;
    next_state.out_of_range = (selected < light_low_threshold) || (selected > light_high_threshold);

    if (reg_req.write) begin
      unique case (reg_req.addr)
        als_aux_pkg::PERSIST_OFFSET: begin
          next_state.persist_filter = reg_req.wdata;
        end
        als_aux_pkg::AUX_PIN_OFFSET: begin
          next_state.aux_ctrl = reg_req.wdata & als_aux_pkg::AUX_PIN_WMASK;
        end
        default: begin
        end
      endcase
    end

    if (reg_req.read) begin
      next_state.rvalid = 1'b1;
      unique case (reg_req.addr)
        als_aux_pkg::PERSIST_OFFSET: begin
          next_state.rdata = state.persist_filter;
        end
        als_aux_pkg::AUX_PIN_OFFSET: begin
          next_state.rdata = aux_readback;
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end

    // Input mode releases the pin so an external driver owns it
    if (aux_in_en) begin
      next_state.pin.oe_n  = 1'b1;
      next_state.pin.level = 1'b1;
    end else begin
      next_state.pin.oe_n  = 1'b0;
      next_state.pin.level = pin_value;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state                <= '0;
      state.persist_filter <= als_aux_pkg::PERSIST_RESET;
      state.aux_ctrl       <= als_aux_pkg::AUX_PIN_RESET;
      state.pin.oe_n       <= 1'b1;
      state.pin.level      <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata          = state.rdata;
  assign reg_rvalid         = state.rvalid;
  assign aux_pin_out        = state.pin.level;
  assign aux_pin_oe_n       = state.pin.oe_n;
  assign light_irq          = filter_irq;
  assign light_irq_level    = filter_met;
  assign prox_persist_count = state.persist_filter[als_aux_pkg::PROX_PERSIST_LSB +: als_aux_pkg::PROX_PERSIST_W];

endmodule
`default_nettype wire

// >>> hdl/als_aux_pkg.sv
// Shared constants and carriers for the light persistence filter and auxiliary pin
package als_aux_pkg;

  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned REG_DATA_W = 8;

  // Register offsets
  localparam logic [7:0] PERSIST_OFFSET = 8'hbd;
  localparam logic [7:0] AUX_PIN_OFFSET = 8'hbe;

  // interrupt_persistence_filter fields
  localparam int unsigned LIGHT_PERSIST_LSB = 0;
  localparam int unsigned LIGHT_PERSIST_W   = 4;
  localparam int unsigned PROX_PERSIST_LSB  = 4;
  localparam int unsigned PROX_PERSIST_W    = 4;
  localparam logic [7:0]  PERSIST_RESET     = 8'h00;

  // aux_pin_control fields
  localparam int unsigned AUX_INVERT_BIT = 3;
  localparam int unsigned AUX_IN_EN_BIT  = 2;
  localparam int unsigned AUX_OUT_BIT    = 1;
  localparam int unsigned AUX_IN_BIT     = 0;
  localparam logic [7:0]  AUX_PIN_RESET  = 8'h02;
  localparam logic [7:0]  AUX_PIN_WMASK  = 8'h0e;

  // Persistence count mapping: short settings count directly, longer ones in steps of five
  localparam int unsigned COUNT_W         = 6;
  localparam logic [3:0]  PERSIST_SHORT   = 4'h3;
  localparam logic [5:0]  PERSIST_STEP    = 6'h05;

  typedef struct packed {
    logic                  write;
    logic                  read;
    logic [REG_ADDR_W-1:0] addr;
    logic [REG_DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_drive_t;

endpackage

// >>> hdl/sync_two_stage.sv
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module sync_two_stage (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;

endmodule
`default_nettype wire

// >>> hdl/light_persist_filter.sv
// Consecutive out-of-range counter that gates the light interrupt
`timescale 1ns/100ps
`default_nettype none
module light_persist_filter #(
  parameter int unsigned COUNT_W = als_aux_pkg::COUNT_W
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       sample_valid,
  input  wire logic       out_of_range,
  input  wire logic [3:0] light_persist_count,
  output logic            irq_pulse,
  output logic            persist_met
);

  typedef struct packed {
    logic [COUNT_W-1:0] run;
    logic               irq;
    logic               met;
  } filter_state_t;

  filter_state_t      state;
  filter_state_t      next_state;
  logic [COUNT_W-1:0] needed;
  logic [COUNT_W-1:0] run_inc;

  always_comb begin
    if (light_persist_count <= als_aux_pkg::PERSIST_SHORT) begin
      needed = COUNT_W'(light_persist_count);
    end else begin
      needed = COUNT_W'(als_aux_pkg::PERSIST_STEP * (light_persist_count - als_aux_pkg::PERSIST_SHORT));
    end
  end

  // Saturating, so a long excursion cannot wrap the run back under the target,
  // even when the setting is lowered below a run already counted
  assign run_inc = (state.run >= needed) ? state.run : COUNT_W'(state.run + 1'b1);

  always_comb begin
    next_state     = state;
    next_state.irq = 1'b0;
    if (sample_valid) begin
      if (light_persist_count == 4'h0) begin
        next_state.irq = 1'b1;
        next_state.met = out_of_range;
        next_state.run = '0;
      end else if (out_of_range) begin
        next_state.run = run_inc;
        next_state.irq = (run_inc >= needed);
        next_state.met = (run_inc >= needed);
      end else begin
        next_state.run = '0;
        next_state.met = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign irq_pulse   = state.irq;
  assign persist_met = state.met;

endmodule
`default_nettype wire

// >>> tb/als_aux_assertions.sv
// Port assertions for the light persistence filter and auxiliary pin
`timescale 1ns/100ps
`default_nettype none
module als_aux_assertions #(
  parameter int unsigned CHANNELS = 5,
  parameter int unsigned DATA_W   = 16,
  parameter int unsigned SEL_W    = 3
) (
  input wire logic                           clk_sys,
  input wire logic                           reset,
  input wire als_aux_pkg::reg_req_t          reg_req,
  input wire logic [7:0]                     reg_rdata,
  input wire logic                           reg_rvalid,
  input wire logic                           light_sample_valid,
  input wire logic [CHANNELS-1:0][DATA_W-1:0] light_result,
  input wire logic [SEL_W-1:0]               light_threshold_source_select,
  input wire logic [DATA_W-1:0]              light_low_threshold,
  input wire logic [DATA_W-1:0]              light_high_threshold,
  input wire logic                           aux_pin_out,
  input wire logic                           aux_pin_oe_n,
  input wire logic                           light_irq,
  input wire logic                           light_irq_level,
  input wire logic [3:0]                     prox_persist_count
);
  logic [DATA_W-1:0] chan;
  logic              oor;
  assign chan = (light_threshold_source_select < CHANNELS) ?
                light_result[light_threshold_source_select] : light_result[0];
  assign oor = (chan < light_low_threshold) || (chan > light_high_threshold);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_unmapped;
    reg_req.read && reg_req.addr != 8'hbd && reg_req.addr != 8'hbe;
  endsequence
  sequence s_in_range;
    light_sample_valid && !oor;
  endsequence
  a_read_answer: assert property (reg_req.read |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.read))
    else $error("answer without read");
  a_unmapped_zero: assert property (s_unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_prox_write: assert property (reg_req.write && reg_req.addr == 8'hbd |=>
    prox_persist_count == $past(reg_req.wdata[7:4])) else $error("prox count not written");
  a_prox_hold: assert property (!$stable(prox_persist_count) |->
    $past(reg_req.write) && $past(reg_req.addr) == 8'hbd) else $error("prox count moved");
  a_irq_timing: assert property (light_irq |-> $past(light_sample_valid, 2))
    else $error("irq without sample");
  a_in_range_clear: assert property (s_in_range |-> ##2 !light_irq_level)
    else $error("level kept after in-range");
  a_input_release: assert property (aux_pin_oe_n |-> aux_pin_out)
    else $error("released pin not high");
endmodule
bind als_persistence_and_aux_pin als_aux_assertions #(.CHANNELS(CHANNELS), .DATA_W(DATA_W),
  .SEL_W(SEL_W)) als_aux_assertions_i (.*);
`default_nettype wire

// >>> tb/aux_pin_partner.sv
// External level source on the auxiliary pin
`timescale 1ns/100ps
`default_nettype none
module aux_pin_partner (
  input  wire logic aux_pin_out,
  input  wire logic aux_pin_oe_n,
  input  wire logic drive_level,
  output logic      aux_pin_in
);
  // Source stays off while the device drives, so the wire shows the device
  assign aux_pin_in = aux_pin_oe_n ? drive_level : aux_pin_out;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Testbench for the light persistence filter and auxiliary pin
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys, reset, light_sample_valid, light_irq_direct_en, aux_pin_irq_routing;
  logic aux_pin_in, aux_pin_out, aux_pin_oe_n, light_irq, light_irq_level, reg_rvalid, drive_level;
  als_aux_pkg::reg_req_t reg_req;
  logic [7:0]        reg_rdata, x;
  logic [4:0][15:0]  light_result;
  logic [2:0]        light_threshold_source_select;
  logic [15:0]       light_low_threshold, light_high_threshold;
  logic [3:0]        prox_persist_count;
  logic [7:0]        rq[$];
  logic [1:0]        iq[$];
  logic [1:0]        sr;
  logic [31:0]       seed;
  logic [3:0]        plist[5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hf};
  logic [7:0]        pins[4] = '{8'h00, 8'h02, 8'h08, 8'h0a};
  int                err_count, compares, cycles, n;
  als_persistence_and_aux_pin als_persistence_and_aux_pin_i (.*);
  aux_pin_partner aux_pin_partner_i (.*);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    rq.push_back(e);
    @(posedge clk_sys);
    reg_req <= '0;
  endtask
  // Unselected channels get the opposite range, so a wrong channel choice shows
  // Selects 5 to 7 fall back to channel zero
  task automatic sample(input logic oor, input logic e);
    logic [31:0] r;
    int          s;
    r = xs();
    s = (r[2:0] < 3'h5) ? int'(r[2:0]) : 0;
    @(posedge clk_sys);
    light_sample_valid <= 1'b1;
    light_threshold_source_select <= r[2:0];
    for (int c = 0; c < 5; c++) begin
      light_result[c] <= ((c == s) == oor) ? (r[7] ? 16'h00c9 : 16'h0063) : (r[8] ? 16'h0064 : 16'h00c8);
    end
    iq.push_back({oor & e, e});
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
    if (reg_rvalid === 1'b1) check(reg_rdata, rq.pop_front());
    if (sr[1]) check({6'h00, light_irq_level, light_irq}, {6'h00, iq.pop_front()});
    sr <= {sr[0], light_sample_valid};
  end
  initial begin
    seed = 32'h0000005e;
    {reset, light_threshold_source_select, light_result} = '1;
    {reg_req, light_sample_valid, light_irq_direct_en, aux_pin_irq_routing, drive_level, sr} = '0;
    light_low_threshold = 16'h0064;
    light_high_threshold = 16'h00c8;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'hbd, 8'h00);
    rd(8'hbe, 8'h02);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    foreach (plist[k]) begin
      n = plist[k] <= 3 ? plist[k] : 5 * (plist[k] - 3);
      x = xs();
      wr(8'hbd, {x[7:4], plist[k]});
      rd(8'hbd, {x[7:4], plist[k]});
      sample(1'b0, plist[k] == 0);
      for (int i = 0; i < n - 1; i++) sample(1'b1, 1'b0);
      sample(1'b0, plist[k] == 0);
      for (int i = 0; i < n; i++) sample(1'b1, i == n - 1);
      sample(1'b1, 1'b1);
      @(posedge clk_sys);
      light_sample_valid <= 1'b0;
    end
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_sys);
      aux_pin_irq_routing <= r[0];
      light_irq_direct_en <= r[0];
      foreach (pins[k]) begin
        wr(8'hbe, pins[k]);
        @(posedge clk_sys);
        #1 check({6'h00, aux_pin_oe_n, aux_pin_out}, {7'h00, (r[0] ? 1'b0 : pins[k][1]) ^ pins[k][3]});
        rd(8'hbe, pins[k]);
      end
    end
    @(posedge clk_sys);
    aux_pin_irq_routing <= 1'b0;
    wr(8'hbe, 8'hff);
    for (int v = 0; v < 2; v++) begin
      drive_level <= v[0];
      repeat (4) @(posedge clk_sys);
      rd(8'hbe, {7'h07, v[0]});
    end
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule
`default_nettype wire
